// [pkg/psc_pkg.sv]
// Package for the point-of-load sync, enable and fault control block
// Assumes a 25 MHz pclk and an APB master on the register side
package psc_pkg;
  // Clock rate and oscillator reference
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned OSC_REF_HZ = 16000000;
  // Divisor limits and the divisors for the four strap frequencies
  localparam logic [5:0] DIV_MIN = 6'h14;
  localparam logic [5:0] DIV_MAX = 6'h28;
  localparam logic [5:0] DIV_571K = 6'h1c;
  localparam logic [5:0] DIV_615K = 6'h1a;
  localparam logic [5:0] DIV_727K = 6'h16;
  localparam logic [5:0] DIV_800K = 6'h14;
  // Frequency range in kHz
  localparam logic [15:0] FREQ_MIN_KHZ = 16'h023b;
  localparam logic [15:0] FREQ_MAX_KHZ = 16'h0320;
  // Timing: minimum enable widths and clock loss timeout
  localparam int unsigned EN_LOW_EXTRA_US = 10500;
  localparam int unsigned EN_HIGH_EXTRA_US = 5500;
  localparam int unsigned EN_LOW_MIN_CYC = (EN_LOW_EXTRA_US * 25);
  localparam int unsigned EN_HIGH_MIN_CYC = (EN_HIGH_EXTRA_US * 25);
  localparam int unsigned LOSS_TICKS = 4;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FREQ = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_PGD = 8'h0c;
  localparam logic [7:0] OFS_CFG = 8'h10;
  // Control fields
  localparam int CTRL_SYNC_OUT = 0;
  localparam int CTRL_FREQ_CMD = 1;
  localparam int CTRL_FLT_STOP = 2;
  localparam int CTRL_FLT_FOLLOW = 3;
  localparam int CTRL_FLT_RESTART = 4;
  localparam int CTRL_FAULT = 5;
  localparam int CTRL_LOAD_CFG = 6;
  // Reset values
  localparam logic [6:0] CTRL_RST = 7'h0c;
  localparam logic [15:0] FREQ_RST = 16'h023b;
  // Clock source states
  typedef enum logic [1:0] {PSC_INTERNAL, PSC_DETECT, PSC_LOCKED} psc_src_t;
  // Per channel state
  typedef struct packed {
    logic on;
    logic pg;
  } psc_chan_t;
endpackage : psc_pkg

// [verilog/psc_core.sv]
// Sync pin, frequency select, edge triggered enables, power good and fault share
// Assumes APB master on pclk; pins and window flags are asynchronous to pclk
// Contract
// - Frequency from 571 to 800 kHz, set by strap or bus command
// - Default switching frequency is 571 kHz
// - Strap codes 0..3 map to 571, 615, 727, 800 kHz
// - Sync pin is an input out of reset
// - Incoming clock is searched when a channel enable rises while running on the internal clock
// - Switching cycle aligns to rising edges of the external clock
// - Lost external clock falls back to internal oscillator
// - Sync output mode drives internal clock out, skips detection
// - Internal frequency is 16 MHz over N, N from 20 to 28
// - Uneven command picks divisor giving closest frequency
// - Channel enables act on edges, not levels
// - Too short high pulse trailing edge is ignored, state kept
// - Default: channel on while enable high, even during bus traffic
// - Loading a configuration restores factory defaults first
// - Power good when output within window and no fault
// - Fault stops module and broadcasts; followers stop and restart
`timescale 1ns/10ps
module psc_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] freq_strap_resistor,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  input wire logic channel_enable_one,
  input wire logic channel_enable_two,
  input wire logic [1:0] vout_in_window,
  output logic power_ok_one,
  output logic power_ok_two,
  input wire logic share_in,
  output logic share_out,
  output logic share_oe,
  output logic sw_tick
);
  // ----------------------------------------
  // Closest divisor search
  // ----------------------------------------
  function automatic logic [5:0] best_div(input logic [15:0] khz);
    logic [5:0] best;
    int unsigned err;
    int unsigned e;
    int unsigned f;
    best = psc_pkg::DIV_571K;
    err = 32'hffffffff;
    for (int n = 20; n <= 40; n++) begin
      f = (psc_pkg::OSC_REF_HZ / 1000) / n;
      e = (f > khz) ? (f - khz) : (khz - f);
      if (e < err) begin
        err = e;
        best = n[5:0];
      end
    end
    return best;
  endfunction : best_div

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [5:0] sy1_reg;
  logic [5:0] sy2_reg;
  logic [5:0] sy3_reg;
  logic [1:0] strap_s1_reg;
  logic [1:0] strap_s2_reg;
  // Two flops per pin, third flop for edge finding; share line idles high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy1_reg <= 6'h20; // No false share fault after reset
      sy2_reg <= 6'h20;
      sy3_reg <= 6'h20;
    end else begin
      sy1_reg <= {share_in, vout_in_window, channel_enable_two, channel_enable_one, sync_in};
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
    end
  end
  // Strap flops keep sampling through reset, so the code is settled at release
  always_ff @(posedge pclk) begin
    strap_s1_reg <= freq_strap_resistor;
    strap_s2_reg <= strap_s1_reg;
  end
  wire sync_rise = sy2_reg[0] & ~sy3_reg[0];
  wire [1:0] en_lvl = sy2_reg[2:1];
  wire [1:0] en_rise = sy2_reg[2:1] & ~sy3_reg[2:1];
  wire [1:0] win_ok = sy2_reg[4:3];
  wire share_fault = ~sy2_reg[5];

  // ----------------------------------------
  // APB register file
  // ----------------------------------------
  logic [6:0] ctrl_reg;
  logic [15:0] freq_reg;
  logic [5:0] div_reg;
  logic strap_done_reg;
  logic [1:0] fault_stop_reg;
  logic bus_fault_reg;
  psc_pkg::psc_src_t src_reg;
  logic [1:0] chan_on_reg;
  wire wr = psel & penable & pwrite;
  wire rd = psel & ~pwrite;
  wire hit = (paddr == psc_pkg::OFS_CTRL) | (paddr == psc_pkg::OFS_FREQ) | (paddr == psc_pkg::OFS_STAT) |
    (paddr == psc_pkg::OFS_PGD) | (paddr == psc_pkg::OFS_CFG);
  wire load_cfg = wr & (paddr == psc_pkg::OFS_CFG) & pwdata[psc_pkg::CTRL_LOAD_CFG];
  wire freq_wr = wr & (paddr == psc_pkg::OFS_FREQ);
  wire [15:0] freq_clip = (pwdata[15:0] < psc_pkg::FREQ_MIN_KHZ) ? psc_pkg::FREQ_MIN_KHZ :
    (pwdata[15:0] > psc_pkg::FREQ_MAX_KHZ) ? psc_pkg::FREQ_MAX_KHZ : pwdata[15:0];
  wire [5:0] strap_div = (strap_s2_reg == 2'h0) ? psc_pkg::DIV_571K :
    (strap_s2_reg == 2'h1) ? psc_pkg::DIV_615K :
    (strap_s2_reg == 2'h2) ? psc_pkg::DIV_727K : psc_pkg::DIV_800K;
  // Writes; strap sampled once after reset release, command overrides
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= psc_pkg::CTRL_RST;
      freq_reg <= psc_pkg::FREQ_RST;
      div_reg <= psc_pkg::DIV_571K;
      strap_done_reg <= 1'b0;
    end else if (load_cfg) begin
      ctrl_reg <= psc_pkg::CTRL_RST;
      freq_reg <= psc_pkg::FREQ_RST;
      div_reg <= psc_pkg::DIV_571K;
    end else begin
      strap_done_reg <= 1'b1;
      if (!strap_done_reg) begin
        div_reg <= strap_div;
      end
      if (wr && paddr == psc_pkg::OFS_CTRL) begin
        ctrl_reg <= pwdata[6:0];
      end
      if (freq_wr) begin
        freq_reg <= freq_clip;
        div_reg <= best_div(freq_clip);
      end
    end
  end
  // Read mux and answer, zero wait states
  wire [31:0] rd_mux = (paddr == psc_pkg::OFS_CTRL) ? {25'h0, ctrl_reg} :
    (paddr == psc_pkg::OFS_FREQ) ? {10'h0, div_reg, freq_reg} :
    (paddr == psc_pkg::OFS_STAT) ? {26'h0, bus_fault_reg, fault_stop_reg, src_reg == psc_pkg::PSC_LOCKED,
      chan_on_reg} :
    (paddr == psc_pkg::OFS_PGD) ? {30'h0, power_ok_two, power_ok_one} : 32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      prdata <= rd ? rd_mux : 32'h0;
    end
  end

  // ----------------------------------------
  // Internal oscillator and clock source
  // ----------------------------------------
  logic [4:0] ref_acc_reg;
  logic [5:0] div_cnt_reg;
  logic [7:0] loss_cnt_reg;
  // 16 MHz reference ticks from 25 MHz by fractional accumulation
  wire [5:0] acc_sum = {1'b0, ref_acc_reg} + 6'h10;
  wire ref_tick = acc_sum >= 6'h19;
  wire int_wrap = ref_tick & (div_cnt_reg >= div_reg - 6'h01);
  wire ext_mode = src_reg == psc_pkg::PSC_LOCKED;
  wire [7:0] loss_lim = {2'h0, div_reg} * 8'(psc_pkg::LOSS_TICKS) / 8'h2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_acc_reg <= 5'h00;
      div_cnt_reg <= 6'h00;
    end else begin
      ref_acc_reg <= ref_tick ? 5'(acc_sum - 6'h19) : acc_sum[4:0];
      if (int_wrap || (ext_mode && sync_rise)) begin
        div_cnt_reg <= 6'h00;
      end else if (ref_tick) begin
        div_cnt_reg <= div_cnt_reg + 6'h01;
      end
    end
  end
  // Detection on enable rise, lock and loss timeout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_reg <= psc_pkg::PSC_INTERNAL;
      loss_cnt_reg <= 8'h00;
    end else begin
      if (sync_rise || ctrl_reg[psc_pkg::CTRL_SYNC_OUT]) begin
        loss_cnt_reg <= 8'h00;
      end else if (ref_tick && loss_cnt_reg != 8'hff) begin
        loss_cnt_reg <= loss_cnt_reg + 8'h01;
      end
      case (src_reg)
        psc_pkg::PSC_INTERNAL: begin
          if (|en_rise && !ctrl_reg[psc_pkg::CTRL_SYNC_OUT]) begin
            src_reg <= psc_pkg::PSC_DETECT;
          end
        end
        psc_pkg::PSC_DETECT: begin
          if (ctrl_reg[psc_pkg::CTRL_SYNC_OUT] || loss_cnt_reg > loss_lim) begin
            src_reg <= psc_pkg::PSC_INTERNAL;
          end else if (sync_rise) begin
            src_reg <= psc_pkg::PSC_LOCKED;
          end
        end
        psc_pkg::PSC_LOCKED: begin
          if (ctrl_reg[psc_pkg::CTRL_SYNC_OUT] || loss_cnt_reg > loss_lim) begin
            src_reg <= psc_pkg::PSC_INTERNAL;
          end
        end
        default: src_reg <= psc_pkg::PSC_INTERNAL;
      endcase
    end
  end
  // Switching tick and sync pin drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_tick <= 1'b0;
      sync_out <= 1'b0;
      sync_oe <= 1'b0;
    end else begin
      sw_tick <= ext_mode ? sync_rise : int_wrap;
      sync_oe <= ctrl_reg[psc_pkg::CTRL_SYNC_OUT];
      sync_out <= ctrl_reg[psc_pkg::CTRL_SYNC_OUT] & (div_cnt_reg < {1'b0, div_reg[5:1]});
    end
  end

  // ----------------------------------------
  // Edge triggered channel enables
  // ----------------------------------------
  logic [23:0] wid_cnt_reg [2];
  logic [1:0] en_last_reg;
  logic [1:0] restart_reg;
  wire [1:0] en_edge = en_lvl ^ en_last_reg;
  wire local_fault = ctrl_reg[psc_pkg::CTRL_FAULT] & ctrl_reg[psc_pkg::CTRL_FLT_STOP];
  wire any_stop = local_fault | (share_fault & ctrl_reg[psc_pkg::CTRL_FLT_FOLLOW]);
  for (genvar c = 0; c < 2; c++) begin : g_ch
    wire long_low = wid_cnt_reg[c] >= 24'(psc_pkg::EN_LOW_MIN_CYC);
    wire long_high = wid_cnt_reg[c] >= 24'(psc_pkg::EN_HIGH_MIN_CYC);
    // Pulse width count, state change on qualified edges, fault stop or restart
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        wid_cnt_reg[c] <= 24'h000000;
        en_last_reg[c] <= 1'b0;
        chan_on_reg[c] <= 1'b0;
        restart_reg[c] <= 1'b0;
      end else begin
        if (en_edge[c]) begin
          wid_cnt_reg[c] <= 24'h000000;
          en_last_reg[c] <= en_lvl[c];
        end else if (!long_low) begin
          wid_cnt_reg[c] <= wid_cnt_reg[c] + 24'h000001; // Saturates at the longer limit
        end
        if (any_stop) begin
          chan_on_reg[c] <= 1'b0;
          restart_reg[c] <= restart_reg[c] | (chan_on_reg[c] & ctrl_reg[psc_pkg::CTRL_FLT_RESTART]);
        end else if (restart_reg[c] && en_lvl[c]) begin
          chan_on_reg[c] <= 1'b1;
          restart_reg[c] <= 1'b0;
        end else if (en_edge[c] && en_lvl[c] && (long_low || !chan_on_reg[c])) begin
          chan_on_reg[c] <= 1'b1;
        end else if (en_edge[c] && !en_lvl[c] && long_high) begin
          chan_on_reg[c] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Power good and fault broadcast
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_ok_one <= 1'b0;
      power_ok_two <= 1'b0;
      share_out <= 1'b0;
      share_oe <= 1'b0;
      fault_stop_reg <= 2'h0;
      bus_fault_reg <= 1'b0;
    end else begin
      power_ok_one <= chan_on_reg[0] & win_ok[0] & ~any_stop;
      power_ok_two <= chan_on_reg[1] & win_ok[1] & ~any_stop;
      share_oe <= local_fault;
      share_out <= 1'b0;
      fault_stop_reg <= {fault_stop_reg[1] | share_fault, fault_stop_reg[0] | local_fault};
      bus_fault_reg <= share_fault;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_RESET_INPUT: assert property (@(posedge pclk) $rose(presetn) |-> !sync_oe)
    else $error("sync pin driven out of reset");
  AST_OUT_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[psc_pkg::CTRL_SYNC_OUT] |=> sync_oe)
    else $error("sync pin not driven in output mode");
  AST_NO_LOCK_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[psc_pkg::CTRL_SYNC_OUT] |=> src_reg != psc_pkg::PSC_LOCKED)
    else $error("locked while sync is output");
  AST_DIV_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    div_reg >= psc_pkg::DIV_MIN && div_reg <= psc_pkg::DIV_MAX)
    else $error("divisor out of range");
  AST_DETECT: assert property (@(posedge pclk) disable iff (!presetn)
    (src_reg == psc_pkg::PSC_INTERNAL && |en_rise && !ctrl_reg[psc_pkg::CTRL_SYNC_OUT])
    |=> src_reg == psc_pkg::PSC_DETECT)
    else $error("no detection on enable");
  AST_LOSS: assert property (@(posedge pclk) disable iff (!presetn)
    (ext_mode && loss_cnt_reg > loss_lim) |=> src_reg == psc_pkg::PSC_INTERNAL)
    else $error("no fallback on clock loss");
  AST_ALIGN: assert property (@(posedge pclk) disable iff (!presetn)
    (ext_mode && sync_rise) |=> sw_tick && div_cnt_reg == 6'h00)
    else $error("cycle not aligned to sync edge");
  AST_PG: assert property (@(posedge pclk) disable iff (!presetn)
    any_stop |=> !power_ok_one && !power_ok_two)
    else $error("power good during fault");
  AST_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    any_stop |=> chan_on_reg == 2'h0)
    else $error("channel on after fault stop");
  AST_SHARE: assert property (@(posedge pclk) disable iff (!presetn)
    local_fault |=> share_oe && !share_out)
    else $error("fault not broadcast");
  AST_SHORT_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    (en_edge[0] && !en_lvl[0] && !g_ch[0].long_high && !any_stop && chan_on_reg[0]) |=> chan_on_reg[0])
    else $error("short high pulse turned channel off");
endmodule : psc_core

// [verif/psc_peer.sv]
// Peer model: an external sync clock source and one peer on the share line
// Assumes the share line has a pull-up and an idle sync line is pulled low
`timescale 1ns/10ps
module psc_peer (
  input wire logic clk_run,
  input wire logic pull_fault,
  input wire logic sync_out,
  input wire logic sync_oe,
  input wire logic share_oe,
  output logic sync_line,
  output logic share_line
);
  // ----------------------------------------
  // Clock source and wire levels
  // ----------------------------------------
  logic src_clk;
  // 320 ns clock, held low while stopped, phase unrelated to pclk
  initial begin
    src_clk = 1'b0;
    #7;
    forever begin
      #160;
      src_clk = clk_run ? ~src_clk : 1'b0;
    end
  end
  // Sync pin follows the device while it drives, else the source
  assign sync_line = sync_oe ? sync_out : src_clk;
  // Open drain share line: low if either party pulls
  assign share_line = ~(share_oe | pull_fault);
endmodule : psc_peer

// [verif/pol_sync_enable_control_test.sv]
// Bench for the sync, enable and fault block: frequency command table, then hand tests
// Assumes psc_core and psc_peer are compiled first; this module is the APB master
`timescale 1ns/10ps
module pol_sync_enable_control_test;
  logic pclk, pready, pslverr, sync_out, sync_oe, sync_line, ok1, ok2, share_oe, share_line, sw_tick, er, sh_out;
  logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, en1 = 1'b0, en2 = 1'b0;
  logic clk_run = 1'b0, pull_fault = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic [1:0] strap = 2'h0;
  logic [1:0] win = 2'h0;
  int n_fail = 0;
  int cmp_count = 0;
  logic [31:0] row_w [0:4] = '{32'h2bc, 32'h32a, 32'h1f4, 32'h267, 32'h320};
  logic [31:0] row_r [0:4] = '{32'h001702bc, 32'h00140320, 32'h001c023b, 32'h001a0267, 32'h00140320};
  logic [5:0] div_tab [0:3] = '{psc_pkg::DIV_571K, psc_pkg::DIV_615K, psc_pkg::DIV_727K, psc_pkg::DIV_800K};

  psc_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .freq_strap_resistor(strap), .sync_in(sync_line), .sync_out(sync_out), .sync_oe(sync_oe),
    .channel_enable_one(en1), .channel_enable_two(en2), .vout_in_window(win), .power_ok_one(ok1),
    .power_ok_two(ok2), .share_in(share_line), .share_out(sh_out), .share_oe(share_oe), .sw_tick(sw_tick));
  psc_peer peer (.clk_run(clk_run), .pull_fault(pull_fault), .sync_out(sync_out), .sync_oe(sync_oe),
    .share_oe(share_oe), .sync_line(sync_line), .share_line(share_line));

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk({31'h0, pready}, 32'h1);
      results();
    end
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk

  // Reads a register until one bit takes a value, bounded
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int i;
    i = 0;
    do begin
      apb(1'b0, a, 32'h0);
      i++;
    end while (rd[b] !== v && i < 100);
    chk({31'h0, rd[b]}, {31'h0, v});
    if (rd[b] !== v) results();
  endtask : poll

  // Counts switching ticks over a window; e or e+1 is right
  task automatic ticks(input int cyc, input int e);
    int n;
    n = 0;
    repeat (cyc) begin
      @(posedge pclk);
      n += (sw_tick === 1'b1);
    end
    chk({31'h0, n == e || n == e + 1}, 32'h1);
  endtask : ticks

  // Counts rising edges of the driven sync pin over a window; e or e+1 is right
  task automatic outs(input int cyc, input int e);
    int n;
    logic p;
    n = 0;
    p = sync_out;
    repeat (cyc) begin
      @(posedge pclk);
      n += (sync_out === 1'b1 && p === 1'b0);
      p = sync_out;
    end
    chk({31'h0, n == e || n == e + 1}, 32'h1);
  endtask : outs

  task automatic rst(input logic [1:0] s);
    @(posedge pclk);
    presetn <= 1'b0;
    strap <= s;
    repeat (20) @(posedge pclk);
    chk({31'h0, sync_oe}, 32'h0);
    presetn <= 1'b1;
  endtask : rst

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst(2'h0);
    rchk(psc_pkg::OFS_CTRL, {25'h0, psc_pkg::CTRL_RST});
    rchk(psc_pkg::OFS_FREQ, {10'h0, psc_pkg::DIV_571K, psc_pkg::FREQ_RST});
    rchk(psc_pkg::OFS_STAT, 32'h0);
    ticks(2000, 45);
    // Frequency command rows: written value and read back divisor and kHz
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, psc_pkg::OFS_FREQ, row_w[k]);
      rchk(psc_pkg::OFS_FREQ, row_r[k]);
    end
    ticks(2010, 64);
    // Unmapped address is refused
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    // Every strap code, each through a reset
    for (int k = 3; k >= 0; k--) begin
      rst(k[1:0]);
      apb(1'b0, psc_pkg::OFS_FREQ, 32'h0);
      chk({26'h0, rd[21:16]}, {26'h0, div_tab[k]});
    end
    // External clock running before the enable rises
    clk_run <= 1'b1;
    repeat (40) @(posedge pclk);
    en1 <= 1'b1;
    poll(psc_pkg::OFS_STAT, 2, 1'b1);
    chk({31'h0, rd[0]}, 32'h1);
    ticks(804, 100);
    // Short high then short low: trailing edge ignored, channel stays on
    en1 <= 1'b0;
    repeat (20) @(posedge pclk);
    apb(1'b0, psc_pkg::OFS_STAT, 32'h0);
    chk({31'h0, rd[0]}, 32'h1);
    en1 <= 1'b1;
    win <= 2'h1;
    poll(psc_pkg::OFS_PGD, 0, 1'b1);
    chk({31'h0, ok1}, 32'h1);
    // Clock lost: back to the internal rate
    clk_run <= 1'b0;
    poll(psc_pkg::OFS_STAT, 2, 1'b0);
    ticks(2000, 45);
    // Sync output mode: drives the pin, no detection
    apb(1'b1, psc_pkg::OFS_CTRL, 32'h0d);
    repeat (2) @(posedge pclk);
    chk({31'h0, sync_oe}, 32'h1);
    clk_run <= 1'b1;
    en2 <= 1'b1;
    repeat (60) @(posedge pclk);
    apb(1'b0, psc_pkg::OFS_STAT, 32'h0);
    chk({29'h0, rd[2:0]}, 32'h3);
    ticks(2000, 45);
    outs(2000, 45);
    clk_run <= 1'b0;
    // Local fault stops and broadcasts, then restart
    apb(1'b1, psc_pkg::OFS_CTRL, 32'h3c);
    poll(psc_pkg::OFS_STAT, 0, 1'b0);
    chk({31'h0, share_oe}, 32'h1);
    chk({31'h0, sh_out}, 32'h0);
    chk({31'h0, ok1}, 32'h0);
    apb(1'b1, psc_pkg::OFS_CTRL, 32'h1c);
    poll(psc_pkg::OFS_STAT, 0, 1'b1);
    chk({31'h0, share_oe}, 32'h0);
    // Peer fault on the share line is followed
    pull_fault <= 1'b1;
    poll(psc_pkg::OFS_STAT, 1, 1'b0);
    pull_fault <= 1'b0;
    poll(psc_pkg::OFS_STAT, 5, 1'b0);
    chk({31'h0, rd[4]}, 32'h1);
    poll(psc_pkg::OFS_STAT, 1, 1'b1);
    // Loading a configuration restores defaults
    apb(1'b1, psc_pkg::OFS_FREQ, 32'h320);
    apb(1'b1, psc_pkg::OFS_CFG, 32'h40);
    rchk(psc_pkg::OFS_CTRL, {25'h0, psc_pkg::CTRL_RST});
    rchk(psc_pkg::OFS_FREQ, {10'h0, psc_pkg::DIV_571K, psc_pkg::FREQ_RST});
    results();
  end
endmodule : pol_sync_enable_control_test
